/* File: bench/cisr_core_model.sv */
// Processor core model that counts the cycles each interrupt line is raised.
`timescale 1ns/1ns
module cisr_core_model (
  input  wire        clock_i,
  input  wire        clear_i,
  input  wire        normal_i,
  input  wire        fast_i,
  output reg  [15:0] normal_cnt_o,
  output reg  [15:0] fast_cnt_o
);
  // A level core samples both lines each cycle; counts saturate rather than wrap.
  always @(posedge clock_i) begin
    if (clear_i) begin
      normal_cnt_o <= 16'h0000;
      fast_cnt_o   <= 16'h0000;
    end else begin
      if (normal_i && normal_cnt_o != 16'hFFFF) normal_cnt_o <= normal_cnt_o + 16'h0001;
      if (fast_i && fast_cnt_o != 16'hFFFF) fast_cnt_o <= fast_cnt_o + 16'h0001;
    end
  end
endmodule

/* File: bench/cisr_top_sva.sv */
// Concurrent checks on the routing outputs and write answers of the control block.
`timescale 1ns/1ns
`include "cisr_regs.vh"
// ----------------------------------------
// Checker
// ----------------------------------------
module cisr_top_sva #(
  parameter ARCH_V2 = 1
) (
  input wire                  clock_i,
  input wire                  rstn_i,
  input wire [`CISR_AW-1:0]   s_axi_awaddr_i,
  input wire                  s_axi_awvalid_i,
  input wire                  s_axi_awready_o,
  input wire [31:0]           s_axi_wdata_i,
  input wire [3:0]            s_axi_wstrb_i,
  input wire                  s_axi_wvalid_i,
  input wire                  s_axi_wready_o,
  input wire [1:0]            s_axi_bresp_o,
  input wire                  s_axi_bvalid_o,
  input wire                  grp0_pend_i,
  input wire                  grp1_pend_i,
  input wire                  bypass_normal_i,
  input wire                  bypass_fast_i,
  input wire                  normal_interrupt_line_o,
  input wire                  fast_interrupt_line_o,
  input wire [`CISR_BP_MSB:0] grp0_preempt_bp_o,
  input wire [`CISR_BP_MSB:0] grp1_preempt_bp_o
);
  reg [1:0] sy_r;
  reg       aw_r;
  reg       w_r;
  reg       s_r;
  reg [7:0] a_r;
  reg [6:0] d_r;
  reg [6:0] c_r;
  wire      live = sy_r[1];
  wire      non  = c_r[1] | (c_r[0] & ~c_r[3]);
  wire      fon  = c_r[0] & c_r[3];
  wire      v2   = (ARCH_V2 != 0);
  // Shadow of the control word; the write lands one edge after both halves are taken.
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sy_r <= 2'h0;
      aw_r <= 1'b0;
      w_r  <= 1'b0;
      s_r  <= 1'b0;
      a_r  <= 8'h00;
      d_r  <= 7'h00;
      c_r  <= 7'h00;
    end else begin
      sy_r <= {sy_r[0], 1'b1};
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_r <= 1'b1;
        a_r  <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_r <= 1'b1;
        d_r <= s_axi_wdata_i[6:0];
        s_r <= s_axi_wstrb_i[0];
      end
      if (aw_r && w_r) begin
        aw_r <= 1'b0;
        w_r  <= 1'b0;
        if (a_r[7:2] == `CISR_IDX_CTRL && s_r)
          c_r <= d_r;
      end
    end
  end
  // The synchronised reset copy gates every check, as the block itself sees it.
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!live);
  AST_NORM_BYPASS: assert property ($past(live && !non) |-> normal_interrupt_line_o ==
    $past(bypass_normal_i & ~(c_r[6] & v2))) else $error("normal bypass wrong");
  AST_FAST_BYPASS: assert property ($past(live && !fon) |-> fast_interrupt_line_o ==
    $past(bypass_fast_i & ~(c_r[5] & v2))) else $error("fast bypass wrong");
  AST_G0_NORMAL: assert property ($past(live && c_r[0] && !c_r[1] && !c_r[3]) |->
    normal_interrupt_line_o == $past(grp0_pend_i)) else $error("group 0 normal wrong");
  AST_G0_FAST: assert property ($past(live && fon) |->
    fast_interrupt_line_o == $past(grp0_pend_i)) else $error("group 0 fast wrong");
  AST_G1_NORMAL: assert property ($past(live && c_r[1] && !c_r[0]) |->
    normal_interrupt_line_o == $past(grp1_pend_i)) else $error("group 1 normal wrong");
  AST_BP_COMMON: assert property ($past(live && c_r[4]) |->
    grp1_preempt_bp_o == grp0_preempt_bp_o) else $error("common binary point wrong");
  AST_RESET_CLEAR: assert property ($rose(live) |-> !normal_interrupt_line_o &&
    !fast_interrupt_line_o && grp0_preempt_bp_o == 3'h0) else $error("reset state wrong");
  AST_B_TIME: assert property (aw_r && w_r |=> s_axi_bvalid_o) else $error("late write answer");
  AST_B_RESP: assert property ($rose(s_axi_bvalid_o) |-> s_axi_bresp_o == ((a_r[7:2] > 6'h03) ?
    `CISR_RESP_SLVERR : `CISR_RESP_OKAY)) else $error("write response wrong");
endmodule
bind cisr_top cisr_top_sva #(.ARCH_V2(ARCH_V2)) u_sva (.*);

/* File: bench/cisr_top_test.sv */
// Register level testbench of the signal routing control block.
`timescale 1ns/1ns
`include "cisr_regs.vh"
module cisr_top_test;
  logic        clock_i = 1'b0, rstn_i = 1'b0, clr = 1'b1;
  logic [7:0]  s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
  logic [31:0] s_axi_wdata_i = 32'h0;
  logic [3:0]  s_axi_wstrb_i = 4'hF;
  logic        s_axi_awvalid_i = 0, s_axi_wvalid_i = 0, s_axi_bready_i = 0;
  logic        s_axi_arvalid_i = 0, s_axi_rready_i = 0;
  logic        grp0_pend_i = 0, grp1_pend_i = 0, bypass_normal_i = 0, bypass_fast_i = 0;
  wire         s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  wire [1:0]   s_axi_bresp_o, s_axi_rresp_o;
  wire [31:0]  s_axi_rdata_o;
  wire         normal_interrupt_line_o, fast_interrupt_line_o;
  wire [2:0]   grp0_preempt_bp_o, grp1_preempt_bp_o;
  wire [15:0]  ncnt, fcnt;
  wire         v1_awready, v1_wready, v1_bvalid, v1_arready, v1_rvalid, v1_norm, v1_fast;
  wire [1:0]   v1_bresp, v1_rresp;
  wire [31:0]  v1_rdata;
  wire [2:0]   v1_bp0, v1_bp1;
  int          errors = 0, checked = 0;
  always #2 clock_i = ~clock_i;
  cisr_top #(.ARCH_V2(1)) DUT (.*);
  cisr_core_model core (.clock_i(clock_i), .clear_i(clr), .normal_i(normal_interrupt_line_o),
    .fast_i(fast_interrupt_line_o), .normal_cnt_o(ncnt), .fast_cnt_o(fcnt));
  // Earlier-version copy on the same inputs; its block bits must never gate a bypass line.
  cisr_top #(.ARCH_V2(0)) DUT_V1 (
    .clock_i(clock_i), .rstn_i(rstn_i),
    .s_axi_awaddr_i(s_axi_awaddr_i), .s_axi_awvalid_i(s_axi_awvalid_i),
    .s_axi_awready_o(v1_awready), .s_axi_wdata_i(s_axi_wdata_i),
    .s_axi_wstrb_i(s_axi_wstrb_i), .s_axi_wvalid_i(s_axi_wvalid_i),
    .s_axi_wready_o(v1_wready), .s_axi_bresp_o(v1_bresp), .s_axi_bvalid_o(v1_bvalid),
    .s_axi_bready_i(s_axi_bready_i), .s_axi_araddr_i(s_axi_araddr_i),
    .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(v1_arready),
    .s_axi_rdata_o(v1_rdata), .s_axi_rresp_o(v1_rresp), .s_axi_rvalid_o(v1_rvalid),
    .s_axi_rready_i(s_axi_rready_i), .grp0_pend_i(grp0_pend_i), .grp1_pend_i(grp1_pend_i),
    .bypass_normal_i(bypass_normal_i), .bypass_fast_i(bypass_fast_i),
    .normal_interrupt_line_o(v1_norm), .fast_interrupt_line_o(v1_fast),
    .grp0_preempt_bp_o(v1_bp0), .grp1_preempt_bp_o(v1_bp1));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task results;
    begin
      $display("errors=%0d checked=%0d", errors, checked);
      if (errors == 0 && checked > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      checked++;
      if (got !== exp) begin
        errors++;
        $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // Write: both channels offered together, each released at its own take.
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    begin
      n = 0;
      s_axi_awaddr_i <= a;
      s_axi_wdata_i <= d;
      s_axi_awvalid_i <= 1'b1;
      s_axi_wvalid_i <= 1'b1;
      s_axi_bready_i <= 1'b1;
      do begin
        @(posedge clock_i);
        n++;
        if (s_axi_awvalid_i && s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
        if (s_axi_wvalid_i && s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
      end while (!s_axi_bvalid_o && n < 100);
      if (n >= 100) begin
        errors++;
        results;
      end
      s_axi_bready_i <= 1'b0;
      chk({30'h0, s_axi_bresp_o}, {30'h0, er});
      @(posedge clock_i);
    end
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    int n;
    begin
      n = 0;
      s_axi_araddr_i <= a;
      s_axi_arvalid_i <= 1'b1;
      s_axi_rready_i <= 1'b1;
      do begin
        @(posedge clock_i);
        n++;
        if (s_axi_arvalid_i && s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
      end while (!s_axi_rvalid_o && n < 100);
      if (n >= 100) begin
        errors++;
        results;
      end
      s_axi_rready_i <= 1'b0;
      chk(s_axi_rdata_o, exp);
      chk({30'h0, s_axi_rresp_o}, {30'h0, er});
      @(posedge clock_i);
    end
  endtask
  task lines(input logic [1:0] exp);
    begin
      repeat (3) @(posedge clock_i);
      chk({30'h0, normal_interrupt_line_o, fast_interrupt_line_o}, {30'h0, exp});
    end
  endtask
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge clock_i);
    rstn_i <= 1'b1;
    clr <= 1'b0;
    repeat (3) @(posedge clock_i);
    rd(8'h00, 32'h0, `CISR_RESP_OKAY);
    rd(8'h10, 32'h0, `CISR_RESP_SLVERR);
    wr(8'h14, 32'h7F, `CISR_RESP_SLVERR);
    grp0_pend_i <= 1'b1;
    wr(8'h00, 32'h01, `CISR_RESP_OKAY);
    lines(2'b10);
    rd(8'h0C, 32'h1, `CISR_RESP_OKAY);
    wr(8'h00, 32'h09, `CISR_RESP_OKAY);
    lines(2'b01);
    grp1_pend_i <= 1'b1;
    wr(8'h00, 32'h0A, `CISR_RESP_OKAY);
    lines(2'b10);
    wr(8'h00, 32'h00, `CISR_RESP_OKAY);
    lines(2'b00);
    bypass_normal_i <= 1'b1;
    bypass_fast_i <= 1'b1;
    lines(2'b11);
    wr(8'h00, 32'h20, `CISR_RESP_OKAY);
    lines(2'b10);
    wr(8'h00, 32'h60, `CISR_RESP_OKAY);
    lines(2'b00);
    chk({30'h0, v1_norm, v1_fast}, 32'h3);
    rd(8'h00, 32'h60, `CISR_RESP_OKAY);
    chk(v1_rdata, 32'h0);
    wr(8'h04, 32'h3, `CISR_RESP_OKAY);
    wr(8'h08, 32'h5, `CISR_RESP_OKAY);
    lines(2'b00);
    chk({26'h0, grp0_preempt_bp_o, grp1_preempt_bp_o}, 32'h1D);
    wr(8'h00, 32'h10, `CISR_RESP_OKAY);
    lines(2'b11);
    chk({26'h0, grp0_preempt_bp_o, grp1_preempt_bp_o}, 32'h1B);
    chk({31'h0, (fcnt != 16'h0) && (ncnt != 16'h0)}, 32'h1);
    rstn_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    rstn_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    rd(8'h00, 32'h0, `CISR_RESP_OKAY);
    chk({26'h0, grp0_preempt_bp_o, grp1_preempt_bp_o}, 32'h0);
    wr(8'h00, 32'h01, `CISR_RESP_OKAY);
    lines(2'b11);
    results;
  end
endmodule

/* File: verilog/cisr_regs.vh */
// Register map and field constants of the signal routing control block.
`ifndef CISR_REGS_VH
`define CISR_REGS_VH

// ---------------------------------------------
// Bus geometry
// ---------------------------------------------
`define CISR_AW          8
`define CISR_IDX_MSB     7
`define CISR_IDX_LSB     2

// ---------------------------------------------
// Register indices (byte address is four times)
// ---------------------------------------------
`define CISR_IDX_CTRL    6'h00
`define CISR_IDX_BP      6'h01
`define CISR_IDX_ABP     6'h02
`define CISR_IDX_STAT    6'h03

// ---------------------------------------------
// Control fields
// ---------------------------------------------
`define CISR_G0_EN       0
`define CISR_G1_EN       1
`define CISR_FAST_SEL    3
`define CISR_CBP_SEL     4
`define CISR_FAST_BLK    5
`define CISR_NORM_BLK    6
`define CISR_BP_MSB      2
`define CISR_ST_NORM     0
`define CISR_ST_FAST     1

// ---------------------------------------------
// Reset values and responses
// ---------------------------------------------
`define CISR_BIT_RST     1'h0
`define CISR_BP_RST      3'h0
`define CISR_ABP_RST     3'h0
`define CISR_RESP_OKAY   2'h0
`define CISR_RESP_SLVERR 2'h2
`define CISR_ZERO32      32'h00000000

`endif

/* File: verilog/cisr_top.v */
// CPU interface signal routing control with its AXI4-Lite register slave.
//
// Our own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ns
`include "cisr_regs.vh"

// Contract
// - Normal signalling off: bypass normal line passes unless normal block bit set.
// - Fast signalling off: bypass fast line passes unless fast block bit set.
// - Earlier architecture version: both block bits reserved, no function.
// - Common select clear: group 0 uses binary point, group 1 aliased one.
// - Common select set: both groups use the binary point register.
// - Group 0 goes on normal line if route select 0, fast if 1.
// - Group 1 always goes on the normal line.
// - Group 0 enable bit gates signalling of group 0 interrupts.
// - Group 1 enable bit gates signalling of group 1 interrupts.
module cisr_top #(
  parameter ARCH_V2 = 1
) (
  input  wire                  clock_i,
  input  wire                  rstn_i,
  input  wire [`CISR_AW-1:0]   s_axi_awaddr_i,
  input  wire                  s_axi_awvalid_i,
  output wire                  s_axi_awready_o,
  input  wire [31:0]           s_axi_wdata_i,
  input  wire [3:0]            s_axi_wstrb_i,
  input  wire                  s_axi_wvalid_i,
  output wire                  s_axi_wready_o,
  output wire [1:0]            s_axi_bresp_o,
  output wire                  s_axi_bvalid_o,
  input  wire                  s_axi_bready_i,
  input  wire [`CISR_AW-1:0]   s_axi_araddr_i,
  input  wire                  s_axi_arvalid_i,
  output wire                  s_axi_arready_o,
  output wire [31:0]           s_axi_rdata_o,
  output wire [1:0]            s_axi_rresp_o,
  output wire                  s_axi_rvalid_o,
  input  wire                  s_axi_rready_i,
  input  wire                  grp0_pend_i,
  input  wire                  grp1_pend_i,
  input  wire                  bypass_normal_i,
  input  wire                  bypass_fast_i,
  output wire                  normal_interrupt_line_o,
  output wire                  fast_interrupt_line_o,
  output wire [`CISR_BP_MSB:0] grp0_preempt_bp_o,
  output wire [`CISR_BP_MSB:0] grp1_preempt_bp_o
);

  // ---------------------------------------------
  // Reset synchroniser
  // ---------------------------------------------
  reg rst_meta_r;
  reg rstn_r;

  // Release is synchronised so no flop sees a runt deassertion.
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_meta_r <= 1'b0;
      rstn_r     <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rstn_r     <= rst_meta_r;
    end
  end

  // ---------------------------------------------
  // Decode helpers
  // ---------------------------------------------
  // Returns the word index of a byte address.
  function [5:0] word_idx;
    input [`CISR_AW-1:0] addr;
    begin
      word_idx = addr[`CISR_IDX_MSB:`CISR_IDX_LSB];
    end
  endfunction

  // High when the address selects a mapped register.
  function mapped;
    input [`CISR_AW-1:0] addr;
    reg   [5:0]          idx;
    begin
      idx    = addr[`CISR_IDX_MSB:`CISR_IDX_LSB];
      mapped = (idx == `CISR_IDX_CTRL) || (idx == `CISR_IDX_BP) ||
               (idx == `CISR_IDX_ABP) || (idx == `CISR_IDX_STAT);
    end
  endfunction

  // ---------------------------------------------
  // Control state
  // ---------------------------------------------
  reg                  g0_en_r;
  reg                  g1_en_r;
  reg                  fast_sel_r;
  reg                  cbp_sel_r;
  reg                  fast_blk_r;
  reg                  norm_blk_r;
  reg [`CISR_BP_MSB:0] bp_r;
  reg [`CISR_BP_MSB:0] abp_r;
  reg                  norm_line_r;
  reg                  fast_line_r;
  reg [`CISR_BP_MSB:0] g0_bp_r;
  reg [`CISR_BP_MSB:0] g1_bp_r;

  // ---------------------------------------------
  // Write channel
  // ---------------------------------------------
  reg                awready_r;
  reg                wready_r;
  reg                aw_full_r;
  reg                w_full_r;
  reg [`CISR_AW-1:0] awaddr_r;
  reg [31:0]         wdata_r;
  reg                wlane0_r;
  reg                bvalid_r;
  reg [1:0]          bresp_r;

  wire aw_take = s_axi_awvalid_i & awready_r;
  wire w_take  = s_axi_wvalid_i & wready_r;
  wire do_wr   = aw_full_r & w_full_r;
  wire wr_ctrl = do_wr & wlane0_r & (word_idx(awaddr_r) == `CISR_IDX_CTRL);
  wire wr_bp   = do_wr & wlane0_r & (word_idx(awaddr_r) == `CISR_IDX_BP);
  wire wr_abp  = do_wr & wlane0_r & (word_idx(awaddr_r) == `CISR_IDX_ABP);

  // Address and data are captured in either order; the response
  // is raised once both are held, then the channel reopens.
  always @(posedge clock_i or negedge rstn_r) begin
    if (!rstn_r) begin
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      aw_full_r <= 1'b0;
      w_full_r  <= 1'b0;
      awaddr_r  <= {`CISR_AW{1'b0}};
      wdata_r   <= `CISR_ZERO32;
      wlane0_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= `CISR_RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_full_r <= 1'b1;
        awready_r <= 1'b0;
        awaddr_r  <= s_axi_awaddr_i;
      end
      if (w_take) begin
        w_full_r <= 1'b1;
        wready_r <= 1'b0;
        wdata_r  <= s_axi_wdata_i;
        wlane0_r <= s_axi_wstrb_i[0];
      end
      if (do_wr) begin
        aw_full_r <= 1'b0;
        w_full_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= mapped(awaddr_r) ? `CISR_RESP_OKAY : `CISR_RESP_SLVERR;
      end
      if (bvalid_r && s_axi_bready_i) begin
        bvalid_r  <= 1'b0;
        awready_r <= 1'b1;
        wready_r  <= 1'b1;
      end
    end
  end

  // ---------------------------------------------
  // Register storage
  // ---------------------------------------------
  // All fields sit in byte lane 0, so only that strobe matters.
  always @(posedge clock_i or negedge rstn_r) begin
    if (!rstn_r) begin
      g0_en_r    <= `CISR_BIT_RST;
      g1_en_r    <= `CISR_BIT_RST;
      fast_sel_r <= `CISR_BIT_RST;
      cbp_sel_r  <= `CISR_BIT_RST;
      fast_blk_r <= `CISR_BIT_RST;
      norm_blk_r <= `CISR_BIT_RST;
      bp_r       <= `CISR_BP_RST;
      abp_r      <= `CISR_ABP_RST;
    end else begin
      if (wr_ctrl) begin
        g0_en_r    <= wdata_r[`CISR_G0_EN];
        g1_en_r    <= wdata_r[`CISR_G1_EN];
        fast_sel_r <= wdata_r[`CISR_FAST_SEL];
        cbp_sel_r  <= wdata_r[`CISR_CBP_SEL];
        if (ARCH_V2 != 0) begin
          fast_blk_r <= wdata_r[`CISR_FAST_BLK];
          norm_blk_r <= wdata_r[`CISR_NORM_BLK];
        end
      end
      if (wr_bp) begin
        bp_r <= wdata_r[`CISR_BP_MSB:0];
      end
      if (wr_abp) begin
        abp_r <= wdata_r[`CISR_BP_MSB:0];
      end
    end
  end

  // ---------------------------------------------
  // Read channel
  // ---------------------------------------------
  reg        arready_r;
  reg        rvalid_r;
  reg [31:0] rdata_r;
  reg [1:0]  rresp_r;
  reg [31:0] rd_word;

  // Read data mux; unused and reserved bits read as zero.
  always @* begin
    rd_word = `CISR_ZERO32;
    case (word_idx(s_axi_araddr_i))
      `CISR_IDX_CTRL: begin
        rd_word[`CISR_G0_EN]    = g0_en_r;
        rd_word[`CISR_G1_EN]    = g1_en_r;
        rd_word[`CISR_FAST_SEL] = fast_sel_r;
        rd_word[`CISR_CBP_SEL]  = cbp_sel_r;
        rd_word[`CISR_FAST_BLK] = fast_blk_r;
        rd_word[`CISR_NORM_BLK] = norm_blk_r;
      end
      `CISR_IDX_BP: begin
        rd_word[`CISR_BP_MSB:0] = bp_r;
      end
      `CISR_IDX_ABP: begin
        rd_word[`CISR_BP_MSB:0] = abp_r;
      end
      `CISR_IDX_STAT: begin
        rd_word[`CISR_ST_NORM] = norm_line_r;
        rd_word[`CISR_ST_FAST] = fast_line_r;
      end
      default: begin
        rd_word = `CISR_ZERO32;
      end
    endcase
  end

  // One read in flight; the address is refused while data waits.
  always @(posedge clock_i or negedge rstn_r) begin
    if (!rstn_r) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= `CISR_ZERO32;
      rresp_r   <= `CISR_RESP_OKAY;
    end else if (s_axi_arvalid_i && arready_r) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rdata_r   <= rd_word;
      rresp_r   <= mapped(s_axi_araddr_i) ? `CISR_RESP_OKAY : `CISR_RESP_SLVERR;
    end else if (rvalid_r && s_axi_rready_i) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
    end
  end

  // ---------------------------------------------
  // Interrupt routing
  // ---------------------------------------------
  reg                  g0_sig;
  reg                  g1_sig;
  reg                  norm_on;
  reg                  fast_on;
  reg                  norm_nxt;
  reg                  fast_nxt;
  reg [`CISR_BP_MSB:0] g1_bp_nxt;

  // A line counts as signalling-disabled when no enabled group is
  // routed to it; only then may the bypass input reach the core.
  always @* begin
    g0_sig  = g0_en_r & grp0_pend_i;
    g1_sig  = g1_en_r & grp1_pend_i;
    norm_on = g1_en_r | (g0_en_r & ~fast_sel_r);
    fast_on = g0_en_r & fast_sel_r;
    norm_nxt = (g0_sig & ~fast_sel_r) | g1_sig;
    fast_nxt = g0_sig & fast_sel_r;
    if (!norm_on) begin
      norm_nxt = bypass_normal_i & ~norm_blk_r;
    end
    if (!fast_on) begin
      fast_nxt = bypass_fast_i & ~fast_blk_r;
    end
    g1_bp_nxt = cbp_sel_r ? bp_r : abp_r;
  end

  // Lines and preemption selects are registered to keep outputs glitch free.
  always @(posedge clock_i or negedge rstn_r) begin
    if (!rstn_r) begin
      norm_line_r <= 1'b0;
      fast_line_r <= 1'b0;
      g0_bp_r     <= `CISR_BP_RST;
      g1_bp_r     <= `CISR_BP_RST;
    end else begin
      norm_line_r <= norm_nxt;
      fast_line_r <= fast_nxt;
      g0_bp_r     <= bp_r;
      g1_bp_r     <= g1_bp_nxt;
    end
  end

  // ---------------------------------------------
  // Output assignments
  // ---------------------------------------------
  assign s_axi_awready_o         = awready_r;
  assign s_axi_wready_o          = wready_r;
  assign s_axi_bresp_o           = bresp_r;
  assign s_axi_bvalid_o          = bvalid_r;
  assign s_axi_arready_o         = arready_r;
  assign s_axi_rdata_o           = rdata_r;
  assign s_axi_rresp_o           = rresp_r;
  assign s_axi_rvalid_o          = rvalid_r;
  assign normal_interrupt_line_o = norm_line_r;
  assign fast_interrupt_line_o   = fast_line_r;
  assign grp0_preempt_bp_o       = g0_bp_r;
  assign grp1_preempt_bp_o       = g1_bp_r;

endmodule
